// [rtl/dasfp_device.sv]
// Device end of the dual converter serial frame port
`timescale 1ns/1ps
module dasfp_device
  import dasfp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  dasfp_if.dev link,
  input wire logic [15:0] sample_a,
  input wire logic [15:0] sample_b,
  output logic sample_take,
  output logic [11:0] config_word,
  output logic [8:0] ref_level_a,
  output logic [8:0] ref_level_b
);
  typedef struct packed {
    logic cs_d;
    logic sclk_d;
    logic in_frame;
    logic single;
    logic rb_frame;
    logic [5:0] cnt;
    logic [15:0] rx;
    logic [11:0] cfg;
    logic [8:0] ref_a;
    logic [8:0] ref_b;
    logic [1:0] rb_sel;
    logic [31:0] sr_a;
    logic [15:0] sr_b;
    logic out_a;
    logic oe_a;
    logic out_b;
    logic oe_b;
    logic take;
  } dasfp_dev_t;

  dasfp_dev_t s;
  dasfp_dev_t next_s;
  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic [5:0] cnt_inc;
  logic [3:0] cmd;

  // Pins come from the host's clock, so all three pass two flops first
  dasfp_sync #(
    .WIDTH(3),
    .RST_VAL(3'b110)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({link.cs_n, link.sclk, link.sdi}),
    .q({cs_s, sclk_s, sdi_s})
  );

  // Read-back word: command nibble on top, value below
  function automatic logic [15:0] rb_word(
    input logic [1:0] sel,
    input logic [11:0] cfg,
    input logic [8:0] ref_a,
    input logic [8:0] ref_b
  );
    unique case (sel)
      2'b11: rb_word = {CMD_RD_CFG, cfg};
      2'b01: rb_word = {CMD_RD_REF_A, ref_a, 3'b000};
      2'b10: rb_word = {CMD_RD_REF_B, ref_b, 3'b000};
      default: rb_word = 16'h0000;
    endcase
  endfunction

  assign cs_fall = s.cs_d & ~cs_s;
  assign cs_rise = ~s.cs_d & cs_s;
  assign sclk_fall = s.sclk_d & ~sclk_s;
  assign cmd = s.rx[CMD_MSB:CMD_LSB];
  // Saturating so an over-long frame never wraps below the minimum
  assign cnt_inc = (s.cnt == EDGES_SAT) ? EDGES_SAT : s.cnt + 6'd1;

  always_comb
  begin
    next_s = s;
    next_s.cs_d = cs_s;
    next_s.sclk_d = sclk_s;
    next_s.take = 1'b0;
    if (cs_fall)
    begin
      // Frame opens; mode is frozen here so late writes wait a frame
      next_s.in_frame = 1'b1;
      next_s.cnt = 6'd0;
      next_s.rx = 16'h0000;
      next_s.single = ~s.cfg[IFACE_SEL_HI] & s.cfg[IFACE_SEL_LO];
      next_s.rb_frame = (s.rb_sel != 2'b00);
      next_s.rb_sel = 2'b00;
      next_s.take = 1'b1;
      next_s.out_a = 1'b0;
      next_s.oe_a = 1'b1;
      next_s.out_b = 1'b0;
      next_s.oe_b = ~next_s.single | next_s.rb_frame;
      if (next_s.rb_frame)
      begin
        next_s.sr_a = {rb_word(s.rb_sel, s.cfg, s.ref_a, s.ref_b), 16'h0000};
        next_s.sr_b = 16'h0000;
      end
      else if (next_s.single)
      begin
        next_s.sr_a = {sample_a, sample_b};
        next_s.sr_b = 16'h0000;
      end
      else
      begin
        next_s.sr_a = {sample_a, 16'h0000};
        next_s.sr_b = sample_b;
      end
    end
    else if (cs_rise && s.in_frame)
    begin
      next_s.in_frame = 1'b0;
      next_s.out_a = 1'b0;
      next_s.out_b = 1'b0;
      next_s.oe_a = 1'b0;
      next_s.oe_b = 1'b0;
      // A short frame falls through with nothing committed
      if (s.cnt >= dasfp_min_edges(s.single))
      begin
        if (!s.rx[CMD_NOP_BIT])
        begin
          case (cmd)
            CMD_WR_CFG: next_s.cfg = s.rx[11:0];
            CMD_WR_REF_A: next_s.ref_a = s.rx[REF_MSB:REF_LSB];
            CMD_WR_REF_B: next_s.ref_b = s.rx[REF_MSB:REF_LSB];
            CMD_RD_REF_A, CMD_RD_REF_B, CMD_RD_CFG: next_s.rb_sel = cmd[1:0];
            default: next_s.rb_sel = 2'b00;
          endcase
        end
      end
    end
    else if (s.in_frame && sclk_fall)
    begin
      if (s.cnt < EDGES_CMD)
      begin
        next_s.rx = {s.rx[14:0], sdi_s};
      end
      next_s.cnt = cnt_inc;
      // Zero fill behind the data gives trailing zeros for free
      if (cnt_inc >= (s.rb_frame ? EDGES_RB_START : EDGES_DATA_START))
      begin
        next_s.out_a = s.sr_a[31];
        next_s.sr_a = {s.sr_a[30:0], 1'b0};
        next_s.out_b = s.sr_b[15] & s.oe_b;
        next_s.sr_b = {s.sr_b[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s.cs_d <= 1'b1;
      s.sclk_d <= 1'b1;
      s.in_frame <= 1'b0;
      s.single <= 1'b0;
      s.rb_frame <= 1'b0;
      s.cnt <= 6'd0;
      s.rx <= 16'h0000;
      s.cfg <= CONFIG_WORD_RST;
      s.ref_a <= REF_LEVEL_RST;
      s.ref_b <= REF_LEVEL_RST;
      s.rb_sel <= 2'b00;
      s.sr_a <= 32'h0000_0000;
      s.sr_b <= 16'h0000;
      s.out_a <= 1'b0;
      s.oe_a <= 1'b0;
      s.out_b <= 1'b0;
      s.oe_b <= 1'b0;
      s.take <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.out_line_a = s.out_a;
  assign link.out_line_a_oe = s.oe_a;
  assign link.out_line_b = s.out_b;
  assign link.out_line_b_oe = s.oe_b;
  assign sample_take = s.take;
  assign config_word = s.cfg;
  assign ref_level_a = s.ref_a;
  assign ref_level_b = s.ref_b;
endmodule

// [rtl/dasfp_host.sv]
// Host end: AXI4-Lite register slave that runs frames on the serial link
`timescale 1ns/1ps
module dasfp_host
  import dasfp_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  dasfp_if.host link,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP} dasfp_st_t;

  typedef struct packed {
    dasfp_st_t st;
    logic [7:0] tmr;
    logic [5:0] cnt;
    logic [5:0] goal;
    logic [15:0] tx;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic [47:0] rx_a;
    logic [47:0] rx_b;
    logic [15:0] word;
    logic [5:0] edges;
    logic follow_rd;
    logic busy;
    logic done;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dasfp_host_t;

  localparam logic [7:0] HALF_M1 = 8'(HALF_CYCLES - 1);
  localparam logic [7:0] GAP_M1 = 8'(2 * HALF_CYCLES - 1);

  dasfp_host_t s;
  dasfp_host_t next_s;
  logic line_a_s;
  logic line_b_s;
  logic [7:0] wofs;
  logic [7:0] rofs;
  logic [31:0] wmask;
  logic do_write;
  logic [5:0] goal;

  // Device must see each SCLK phase through its two-flop sampler
  if (HALF_CYCLES < 4 || HALF_CYCLES > 127)
  begin : g_chk_half
    $error("dasfp_host: HALF_CYCLES out of range 4..127");
  end
  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_chk_addr
    $error("dasfp_host: ADDR_W out of range 5..8");
  end

  dasfp_sync #(
    .WIDTH(2),
    .RST_VAL(2'b00)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({link.line_a, link.line_b}),
    .q({line_a_s, line_b_s})
  );

  assign wofs = 8'(s.awaddr);
  assign rofs = 8'(s_axi_araddr);
  assign wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
  assign do_write = s.aw_have & s.w_have & ~s.bvalid;
  // Read frames, and the frame after one, are stretched to the read length
  assign goal = ((dasfp_is_read(s.word[15:12]) || s.follow_rd) && s.edges < EDGES_READ)
    ? EDGES_READ : s.edges;

  always_comb
  begin
    next_s = s;
    // Write channels, taken in either order
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_have = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_have = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
    end
    // Frame engine
    unique case (s.st)
      ST_IDLE:
      begin
        next_s.cs_n = 1'b1;
        next_s.sclk = 1'b1;
        next_s.sdi = 1'b0;
      end
      ST_LEAD:
      begin
        if (s.tmr == 8'd0)
        begin
          next_s.tmr = HALF_M1;
          next_s.st = (s.goal == 6'd0) ? ST_TAIL : ST_LOW;
          next_s.sclk = (s.goal == 6'd0);
        end
      end
      ST_LOW:
      begin
        if (s.tmr == 8'd0)
        begin
          next_s.tmr = HALF_M1;
          next_s.st = ST_HIGH;
          next_s.sclk = 1'b1;
          next_s.tx = {s.tx[14:0], 1'b0};
          next_s.sdi = s.tx[14];
        end
      end
      ST_HIGH:
      begin
        if (s.tmr == 8'd0)
        begin
          next_s.tmr = HALF_M1;
          next_s.rx_a = {s.rx_a[46:0], line_a_s};
          next_s.rx_b = {s.rx_b[46:0], line_b_s};
          next_s.cnt = s.cnt + 6'd1;
          next_s.st = (s.cnt + 6'd1 == s.goal) ? ST_TAIL : ST_LOW;
          next_s.sclk = (s.cnt + 6'd1 == s.goal);
        end
      end
      ST_TAIL:
      begin
        if (s.tmr == 8'd0)
        begin
          next_s.tmr = GAP_M1;
          next_s.cs_n = 1'b1;
          next_s.sdi = 1'b0;
          next_s.st = ST_GAP;
        end
      end
      ST_GAP:
      begin
        if (s.tmr == 8'd0)
        begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          next_s.st = ST_IDLE;
        end
      end
    endcase
    if (s.st != ST_IDLE && s.tmr != 8'd0)
    begin
      next_s.tmr = s.tmr - 8'd1;
    end
    // Register writes
    if (do_write)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (wofs)
        OFS_WORD: next_s.word = 16'((32'(s.word) & ~wmask) | (s.wdata & wmask));
        OFS_EDGES: next_s.edges = 6'((32'(s.edges) & ~wmask) | (s.wdata & wmask));
        OFS_GO:
        begin
          // A start while busy is dropped; STATUS shows busy
          if (s.st == ST_IDLE && s.wstrb[0] && s.wdata[0])
          begin
            next_s.st = ST_LEAD;
            next_s.tmr = HALF_M1;
            next_s.cs_n = 1'b0;
            next_s.tx = s.word;
            next_s.sdi = s.word[15];
            next_s.cnt = 6'd0;
            next_s.goal = goal;
            next_s.follow_rd = dasfp_is_read(s.word[15:12]) && !s.word[CMD_NOP_BIT];
            next_s.rx_a = 48'h0;
            next_s.rx_b = 48'h0;
            next_s.busy = 1'b1;
          end
        end
        OFS_STATUS:
        begin
          if (s.wstrb[0] && s.wdata[STAT_DONE] && !(s.st == ST_GAP && s.tmr == 8'd0))
          begin
            next_s.done = 1'b0;
          end
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      case (rofs)
        OFS_WORD: next_s.rdata = {16'h0000, s.word};
        OFS_EDGES: next_s.rdata = {26'h0, s.edges};
        OFS_GO: next_s.rdata = 32'h0000_0000;
        OFS_STATUS: next_s.rdata = {30'h0, s.done, s.busy};
        OFS_RXA_HI: next_s.rdata = {16'h0000, s.rx_a[47:32]};
        OFS_RXA_LO: next_s.rdata = s.rx_a[31:0];
        OFS_RXB_HI: next_s.rdata = {16'h0000, s.rx_b[47:32]};
        OFS_RXB_LO: next_s.rdata = s.rx_b[31:0];
        default:
        begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_s.awready = ~next_s.aw_have & ~next_s.bvalid;
    next_s.wready = ~next_s.w_have & ~next_s.bvalid;
    next_s.arready = ~next_s.rvalid;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.cs_n <= 1'b1;
      s.sclk <= 1'b1;
      s.edges <= EDGES_RST;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.cs_n = s.cs_n;
  assign link.sclk = s.sclk;
  assign link.sdi = s.sdi;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
endmodule

// [rtl/dasfp_if.sv]
// Serial frame link between the host end and the device end
`timescale 1ns/1ps
interface dasfp_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic out_line_a;
  logic out_line_a_oe;
  logic out_line_b;
  logic out_line_b_oe;
  // Resolved pin levels seen by the host; a released line reads low, as with a pull-down
  wire line_a;
  wire line_b;

  assign line_a = out_line_a_oe & out_line_a;
  assign line_b = out_line_b_oe & out_line_b;

  modport dev (
    input cs_n,
    input sclk,
    input sdi,
    output out_line_a,
    output out_line_a_oe,
    output out_line_b,
    output out_line_b_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output sdi,
    input line_a,
    input line_b
  );
endinterface

// [rtl/dasfp_pkg.sv]
// Shared constants, command codes and helpers for the dual converter frame port
package dasfp_pkg;

  // Frame lengths in SCLK falling edges
  localparam logic [5:0] EDGES_DUAL = 6'd32;
  localparam logic [5:0] EDGES_SINGLE = 6'd48;
  localparam logic [5:0] EDGES_READ = 6'd48;
  localparam logic [5:0] EDGES_CMD = 6'd16;
  localparam logic [5:0] EDGES_DATA_START = 6'd16;
  localparam logic [5:0] EDGES_RB_START = 6'd1;
  localparam logic [5:0] EDGES_SAT = 6'h3F;

  // Command nibble, bits 15..12 of the captured word
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int CMD_NOP_BIT = 14;
  localparam logic [3:0] CMD_RD_REF_A = 4'h1;
  localparam logic [3:0] CMD_RD_REF_B = 4'h2;
  localparam logic [3:0] CMD_RD_CFG = 4'h3;
  localparam logic [3:0] CMD_WR_CFG = 4'h8;
  localparam logic [3:0] CMD_WR_REF_A = 4'h9;
  localparam logic [3:0] CMD_WR_REF_B = 4'hA;

  // Configuration word fields, and the reference value field of the captured word
  localparam int IFACE_SEL_HI = 11;
  localparam int IFACE_SEL_LO = 10;
  localparam int REF_MSB = 11;
  localparam int REF_LSB = 3;

  // Reset values
  localparam logic [11:0] CONFIG_WORD_RST = 12'h000;
  localparam logic [8:0] REF_LEVEL_RST = 9'h000;

  // Host serial clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 50;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host register offsets (byte addresses)
  localparam logic [7:0] OFS_WORD = 8'h00;
  localparam logic [7:0] OFS_EDGES = 8'h04;
  localparam logic [7:0] OFS_GO = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RXA_HI = 8'h10;
  localparam logic [7:0] OFS_RXA_LO = 8'h14;
  localparam logic [7:0] OFS_RXB_HI = 8'h18;
  localparam logic [7:0] OFS_RXB_LO = 8'h1C;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [5:0] EDGES_RST = 6'd32;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Minimum falling edges that validate a frame in the given mode
  function automatic logic [5:0] dasfp_min_edges(input logic single);
    dasfp_min_edges = single ? EDGES_SINGLE : EDGES_DUAL;
  endfunction

  // True for the three read-back command codes
  function automatic logic dasfp_is_read(input logic [3:0] cmd);
    dasfp_is_read = (cmd == CMD_RD_REF_A) || (cmd == CMD_RD_REF_B) || (cmd == CMD_RD_CFG);
  endfunction

endpackage

// [rtl/dasfp_sync.sv]
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module dasfp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dasfp_sync_t;

  dasfp_sync_t s;
  dasfp_sync_t next_s;

  if (WIDTH < 1)
  begin : g_chk
    $error("dasfp_sync: WIDTH must be at least 1");
  end

  // The first stage feeds only the second
  always_comb
  begin
    next_s.meta = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= {RST_VAL, RST_VAL};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign q = s.stable;
endmodule

// [tb/dasfp_checker.sv]
// Assertions on the serial link between host and device ends
`timescale 1ns/1ps
module dasfp_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic out_line_a,
  input wire logic out_line_a_oe,
  input wire logic out_line_b,
  input wire logic out_line_b_oe
);
  logic sclk_q;
  logic cs_q;
  logic [5:0] cnt;
  logic [3:0] since;
  // Saturating counts, so long frames or idle gaps never wrap
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_q <= 1'b1;
      cs_q <= 1'b1;
      cnt <= 6'h00;
      since <= 4'hF;
    end
    else
    begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      // Held past the frame end, while the outputs are still being released
      if (cs_q && !cs_n)
        cnt <= 6'h00;
      else if (sclk_q && !sclk && cnt != 6'h3F)
        cnt <= cnt + 6'h01;
      if (sclk_q && !sclk)
        since <= 4'h0;
      else if (since != 4'hF)
        since <= since + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_idle_sclk_high: assert property (cs_n |-> sclk)
    else $error("serial clock low outside a frame");
  a_start_zero: assert property ($fell(cs_n) |-> ##[1:6] (out_line_a_oe && !out_line_a))
    else $error("line a not driven low after frame start");
  a_first_drive_zero: assert property ($rose(out_line_a_oe) |-> !out_line_a)
    else $error("line a first driven level not zero");
  a_end_release: assert property ($rose(cs_n) |-> ##[1:6] !(out_line_a_oe || out_line_b_oe))
    else $error("outputs still driven after frame end");
  a_idle_undriven: assert property (cs_n [*8] |-> !(out_line_a_oe || out_line_b_oe))
    else $error("output driven between frames");
  a_b_with_a: assert property (out_line_b_oe |-> out_line_a_oe)
    else $error("line b driven without line a");
  a_conv_zero: assert property ((cnt < 6'd16 && out_line_b_oe) |-> !out_line_b)
    else $error("line b not zero during conversion");
  a_tail_zero: assert property ((cnt > 6'd32 && out_line_b_oe) |-> !out_line_b)
    else $error("line b not zero after last bit");
  a_launch_on_fall: assert property (($changed(out_line_a) && out_line_a_oe
    && $past(out_line_a_oe)) |-> (since >= 4'd1 && since <= 4'd6))
    else $error("line a changed away from a falling edge");
  a_sdi_on_rise: assert property ((!cs_n && !$past(cs_n) && $changed(sdi)) |-> $rose(sclk))
    else $error("sdi changed while serial clock low");
endmodule

// [tb/dual_adc_serial_frame_port_tb.sv]
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
module dual_adc_serial_frame_port_tb;
  import dasfp_pkg::*;
  logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready, mon, b_seen, take;
  logic [7:0] takes;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [15:0] smp_a, smp_b;
  logic [11:0] cfg, ecfg;
  logic [8:0] ref_a, ref_b, era, erb;
  int error_cnt, checked;

  dasfp_if link ();
  dasfp_host i_dasfp_host (.ref_clk(ref_clk), .rst(rst), .link(link.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  dasfp_device i_dasfp_device (.ref_clk(ref_clk), .rst(rst), .link(link.dev),
    .sample_a(smp_a), .sample_b(smp_b), .sample_take(take), .config_word(cfg),
    .ref_level_a(ref_a), .ref_level_b(ref_b));
  dasfp_checker i_dasfp_checker (.ref_clk(ref_clk), .rst(rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .sdi(link.sdi), .out_line_a(link.out_line_a),
    .out_line_a_oe(link.out_line_a_oe), .out_line_b(link.out_line_b),
    .out_line_b_oe(link.out_line_b_oe));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (mon && link.out_line_b_oe !== 1'b0)
      b_seen = 1'b1;
    if (take !== 1'b0)
      takes = takes + 8'h01;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic give_up();
    error_cnt++;
    $display("Error wait limit expected done seen hang");
    test_done();
  endtask

  task automatic chk(input string n, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Both channels offered together; bready and rready stay high, so calls in a row
  // never lower and raise them in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    if (n >= 100)
      give_up();
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    if (n >= 100)
      give_up();
  endtask

  // One frame of w with e falling edges (raised to 48 for a read and the frame after it), then done is cleared
  task automatic frame(input logic [15:0] w, input logic [5:0] e);
    int n;
    n = 0;
    wr(OFS_WORD, {16'h0000, w});
    wr(OFS_EDGES, {26'h0, e});
    wr(OFS_GO, 32'h0000_0001);
    do
    begin
      rd(OFS_STATUS);
      n++;
    end while (d[STAT_DONE] !== 1'b1 && n < 300);
    if (n >= 300)
      give_up();
    wr(OFS_STATUS, 32'h0000_0002);
  endtask

  task automatic chk_regs();
    chk("config_word", {36'h0, cfg}, {36'h0, ecfg});
    chk("ref_level_a", {39'h0, ref_a}, {39'h0, era});
    chk("ref_level_b", {39'h0, ref_b}, {39'h0, erb});
  endtask

  task automatic t_reset();
    ecfg = CONFIG_WORD_RST;
    era = REF_LEVEL_RST;
    erb = REF_LEVEL_RST;
    chk_regs();
    rd(OFS_EDGES);
    chk("edges", {16'h0, d}, {42'h0, EDGES_RST});
    rd(8'h20);
    chk("unmapped rd", {14'h0, r, d}, {14'h0, RESP_SLVERR, 32'h0});
    wr(8'h24, 32'h0000_00FF);
    chk("unmapped wr", {46'h0, r}, {46'h0, RESP_SLVERR});
    $display("test reset done");
  endtask

  task automatic t_dual();
    smp_a <= 16'hA5C3;
    smp_b <= 16'h3C5A;
    takes = 8'h00;
    frame(16'h0000, 6'd32);
    chk("sample take", {40'h0, takes}, 48'd1);
    rd(OFS_RXA_LO);
    chk("dual a", {16'h0, d}, {31'h0, 16'hA5C3, 1'b0});
    rd(OFS_RXB_LO);
    chk("dual b", {16'h0, d}, {31'h0, 16'h3C5A, 1'b0});
    chk_regs();
    $display("test dual done");
  endtask

  // Each write one edge short first, then at the minimum
  task automatic t_write();
    logic [15:0] w [3];
    w = '{16'h8ABC, 16'h95A7, 16'hAE38};
    foreach (w[i])
    begin
      frame(w[i], 6'd31);
      chk_regs();
      frame(w[i], 6'd32);
      case (w[i][15:12])
        CMD_WR_CFG: ecfg = w[i][11:0];
        CMD_WR_REF_A: era = w[i][REF_MSB:REF_LSB];
        default: erb = w[i][REF_MSB:REF_LSB];
      endcase
      chk_regs();
    end
    $display("test write done");
  endtask

  task automatic t_nop();
    logic [15:0] w [4];
    w = '{16'h0FFF, 16'hBFFF, 16'h4FFF, 16'hDFFF};
    foreach (w[i])
    begin
      frame(w[i], 6'd32);
      chk_regs();
    end
    $display("test nop done");
  endtask

  task automatic t_abort();
    smp_a <= 16'hD00D;
    frame(16'h8123, 6'd20);
    chk_regs();
    rd(OFS_RXA_LO);
    chk("abort a", {28'h0, d[19:0]}, {43'h0, 5'b11010});
    $display("test abort done");
  endtask

  task automatic t_readback();
    logic [3:0] c [3];
    logic [15:0] exp;
    c = '{CMD_RD_CFG, CMD_RD_REF_A, CMD_RD_REF_B};
    foreach (c[i])
    begin
      frame({c[i], 12'h000}, 6'd32);
      exp = (c[i] == CMD_RD_CFG) ? {c[i], ecfg} :
        {c[i], (c[i] == CMD_RD_REF_A) ? era : erb, 3'b000};
      // A write sent in the read-back frame lands at its close
      frame((c[i] == CMD_RD_REF_A) ? 16'h9FF8 : 16'h0000, 6'd32);
      if (c[i] == CMD_RD_REF_A)
        era = 9'h1FF;
      chk_regs();
      rd(OFS_RXA_HI);
      chk("readback hi", {32'h0, d[15:0]}, {32'h0, exp});
      rd(OFS_RXA_LO);
      chk("readback lo", {16'h0, d}, 48'h0);
      rd(OFS_RXB_LO);
      chk("readback b", {16'h0, d}, 48'h0);
    end
    $display("test readback done");
  endtask

  task automatic t_single();
    logic [47:0] exp;
    frame(16'h8400, 6'd32);
    ecfg = 12'h400;
    chk_regs();
    smp_a <= 16'h9E61;
    smp_b <= 16'h4B2D;
    b_seen = 1'b0;
    mon = 1'b1;
    frame(16'h0000, 6'd48);
    mon = 1'b0;
    exp = {15'h0, 16'h9E61, 16'h4B2D, 1'b0};
    rd(OFS_RXA_HI);
    chk("single hi", {32'h0, d[15:0]}, {32'h0, exp[47:32]});
    rd(OFS_RXA_LO);
    chk("single lo", {16'h0, d}, {16'h0, exp[31:0]});
    chk("line b oe", {47'h0, b_seen}, 48'h0);
    frame(16'h8000, 6'd32);
    chk_regs();
    frame(16'h8000, 6'd48);
    ecfg = 12'h000;
    chk_regs();
    $display("test single done");
  endtask

  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, mon, b_seen} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    smp_a = 16'h0000;
    smp_b = 16'h0000;
    error_cnt = 0;
    checked = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_dual();
    t_write();
    t_nop();
    t_abort();
    t_readback();
    t_single();
    test_done();
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    give_up();
  end
endmodule
